// [verilog/write_cmd_pkg.sv]
// Package with register map, field layout, status codes and timing for the write command decoder.
`default_nettype none
package write_cmd_pkg;

  // --------------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORD_FIRST = 8'h04;
  localparam logic [7:0] OFS_WORD_LAST = 8'h30;
  localparam logic [7:0] OFS_SLBA_LO = 8'h34;
  localparam logic [7:0] OFS_SLBA_HI = 8'h38;
  localparam logic [7:0] OFS_BLK_COUNT = 8'h3c;
  localparam logic [7:0] OFS_ATTR = 8'h40;
  localparam logic [7:0] OFS_COMPL = 8'h44;
  localparam logic [7:0] OFS_INT_STAT = 8'h48;
  localparam logic [7:0] OFS_INT_MASK = 8'h4c;

  // --------------------------------------------------------------------------
  // Command word array indices
  // --------------------------------------------------------------------------
  localparam int NUM_WORDS = 12;
  localparam int W_MPTR_LO = 0;
  localparam int W_MPTR_HI = 1;
  localparam int W_PRP1_LO = 2;
  localparam int W_PRP1_HI = 3;
  localparam int W_PRP2_LO = 4;
  localparam int W_PRP2_HI = 5;
  localparam int W_DW10 = 6;
  localparam int W_DW11 = 7;
  localparam int W_DW12 = 8;
  localparam int W_DW13 = 9;
  localparam int W_DW14 = 10;
  localparam int W_DW15 = 11;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_PI_EN = 2;
  localparam int CTRL_ID_LSB = 16;
  localparam int DW12_LR = 31;
  localparam int DW12_FUA = 30;
  localparam int DW12_PI_MSB = 29;
  localparam int DW12_PI_LSB = 26;
  localparam int DW12_NLB_MSB = 15;
  localparam int DSM_INCOMP = 7;
  localparam int DSM_SEQ = 6;
  localparam int DSM_LAT_MSB = 5;
  localparam int DSM_LAT_LSB = 4;
  localparam int DSM_FREQ_MSB = 3;
  localparam int INT_POSTED = 0;
  localparam int INT_ERROR = 1;
  localparam int INT_BITS = 2;

  // --------------------------------------------------------------------------
  // Reset values and codes
  // --------------------------------------------------------------------------
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_CONFLICT = 8'h80;
  localparam logic [7:0] SC_BAD_PI = 8'h81;
  localparam logic [3:0] FREQ_WRITE_MAX = 4'h6;
  localparam logic [3:0] FREQ_READ_MAX = 4'h8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LAT_NONE = 2'b00,
    LAT_IDLE = 2'b01,
    LAT_NORMAL = 2'b10,
    LAT_LOW = 2'b11
  } latency_t;

  typedef enum logic [1:0] {
    PRP_ONE = 2'b00,
    PRP_TWO = 2'b01,
    PRP_LIST = 2'b10
  } prp_mode_t;

  // --------------------------------------------------------------------------
  // Transfer geometry and timing
  // --------------------------------------------------------------------------
  localparam logic [26:0] PAGE_BYTES = 27'h000_1000;
  localparam int BLOCK_SHIFT = 9;
  localparam int CLK_PERIOD_NS = 8;
  localparam int COMMIT_NS = 64;
  localparam int COMMIT_CYCLES = (COMMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] COMMIT_LOAD = 8'(COMMIT_CYCLES);

endpackage
`default_nettype wire

// [verilog/write_cmd_fields.sv]
// Combinational field decode of one submitted Read or Write command.
`timescale 1ns/1ps
`default_nettype none
module write_cmd_fields
  import write_cmd_pkg::*;
(
  // Command
  input wire logic is_write,
  input wire logic pi_enable,
  input wire logic [31:0] prp1_lo,
  input wire logic [31:0] dw10,
  input wire logic [31:0] dw11,
  input wire logic [31:0] dw12,
  input wire logic [31:0] dw13,
  // Decoded fields
  output logic [63:0] slba,
  output logic [16:0] blk_count,
  output logic limited_retry,
  output logic force_commit,
  output logic [3:0] prinfo,
  output logic incompressible,
  output logic sequential,
  output latency_t latency,
  output logic [3:0] frequency,
  output prp_mode_t prp_mode,
  output logic [7:0] status
);

  logic [25:0] bytes;
  logic [26:0] end_ofs;

  // --------------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------------
  // Reserved bits 25:16 of dword 12 and 31:8 of dword 13 are never looked at.
  always_comb begin
    slba = {dw11, dw10}; // [R9]
    blk_count = {1'b0, dw12[DW12_NLB_MSB:0]} + 17'h0_0001; // [R13] [R19]
    limited_retry = dw12[DW12_LR]; // [R10]
    force_commit = dw12[DW12_FUA]; // [R11]
    prinfo = dw12[DW12_PI_MSB:DW12_PI_LSB]; // [R12]
    incompressible = dw13[DSM_INCOMP]; // [R14]
    sequential = dw13[DSM_SEQ]; // [R15]
    latency = latency_t'(dw13[DSM_LAT_MSB:DSM_LAT_LSB]); // [R16] [R17]
    frequency = dw13[DSM_FREQ_MSB:0]; // [R18]
  end

  // --------------------------------------------------------------------------
  // Data pointer use
  // --------------------------------------------------------------------------
  always_comb begin
    bytes = {9'h000, blk_count} << BLOCK_SHIFT;
    end_ofs = {15'h0000, prp1_lo[11:0]} + {1'b0, bytes}; // [R7]
    if (end_ofs <= PAGE_BYTES) begin
      prp_mode = PRP_ONE; // [R8]
    end else if (end_ofs <= (PAGE_BYTES << 1)) begin
      prp_mode = PRP_TWO; // [R8]
    end else begin
      prp_mode = PRP_LIST; // [R8]
    end
  end

  // --------------------------------------------------------------------------
  // Status check
  // --------------------------------------------------------------------------
  always_comb begin
    status = SC_SUCCESS;
    if (is_write ? (frequency > FREQ_WRITE_MAX) : (frequency > FREQ_READ_MAX)) begin
      status = SC_CONFLICT; // [R2]
    end else if (!pi_enable && (prinfo[2:0] != 3'h0)) begin
      status = SC_BAD_PI; // [R3]
    end
  end

endmodule
`default_nettype wire

// [verilog/write_command_decoder.sv]
// AXI4-Lite command decoder that checks a command and posts its completion status.
//
// Contract
// [R1] Every finished Read or Write posts a completion entry with its status.
// [R2] Contradictory command attributes complete with status 80h.
// [R3] Invalid protection-information settings complete with status 81h.
// [R4] A Write takes its data, metadata and optional protection information.
// [R5] Only metadata pointer, both data pointers and dwords 10 to 15 are used.
// [R6] Host gives a contiguous, dword-aligned 64-bit metadata pointer.
// [R7] First data pointer is the first source location of write data.
// [R8] Second pointer is unused, second source, or list pointer by transfer size.
// [R9] Starting block address is dword 11 high half and dword 10 low half.
// [R10] Dword 12 bit 31 selects limited retry or full recovery effort.
// [R11] Dword 12 bit 30 forces commit to media before completion.
// [R12] Dword 12 bits 29 to 26 are the protection action and check field.
// [R13] Dword 12 bits 15 to 0 hold a zero-based block count.
// [R14] Hint bit set marks written blocks as not compressible.
// [R15] Hint bit 6 set marks the command part of a sequential series.
// [R16] Latency hint 00b none, 01b idle, 10b normal.
// [R17] Latency hint 11b asks for the smallest latency.
// [R18] Frequency hint bits 3 to 0; write 0110b one-time, above reserved.
// [R19] Reserved bits of dwords 12 and 13 are written zero and ignored.
`timescale 1ns/1ps
`default_nettype none
module write_command_decoder
  import write_cmd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_COMMIT = 2'b10,
    ST_POST = 2'b11
  } state_t;

  state_t state_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_mask;
  logic [31:0] word_reg [NUM_WORDS];
  logic [31:0] ctrl_reg;
  logic start_reg;
  logic [INT_BITS-1:0] int_stat_reg;
  logic [INT_BITS-1:0] int_mask_reg;
  logic [7:0] commit_cnt_reg;
  logic [63:0] slba_reg;
  logic [16:0] blk_count_reg;
  logic [31:0] attr_reg;
  logic [7:0] status_reg;
  logic [15:0] compl_id_reg;
  logic posted_pulse;
  logic [63:0] slba;
  logic [16:0] blk_count;
  logic limited_retry;
  logic force_commit;
  logic [3:0] prinfo;
  logic incompressible;
  logic sequential;
  latency_t latency;
  logic [3:0] frequency;
  prp_mode_t prp_mode;
  logic [7:0] status;
  logic [31:0] rd_word;
  logic rd_hit;

  // --------------------------------------------------------------------------
  // Field decoder
  // --------------------------------------------------------------------------
  write_cmd_fields write_cmd_fields_i (
    .is_write(ctrl_reg[CTRL_WRITE]),
    .pi_enable(ctrl_reg[CTRL_PI_EN]),
    .prp1_lo(word_reg[W_PRP1_LO]),
    .dw10(word_reg[W_DW10]),
    .dw11(word_reg[W_DW11]),
    .dw12(word_reg[W_DW12]),
    .dw13(word_reg[W_DW13]),
    .slba(slba),
    .blk_count(blk_count),
    .limited_retry(limited_retry),
    .force_commit(force_commit),
    .prinfo(prinfo),
    .incompressible(incompressible),
    .sequential(sequential),
    .latency(latency),
    .frequency(frequency),
    .prp_mode(prp_mode),
    .status(status)
  );

  // --------------------------------------------------------------------------
  // Write channels
  // --------------------------------------------------------------------------
  // Address and data are taken in either order; the write lands once both are held.
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                    {8{w_strb_reg[0]}}};

  always_comb begin
    wr_hit = (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg <= OFS_INT_MASK);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Command words
  // --------------------------------------------------------------------------
  // Only the metadata pointer, both data pointers and dwords 10 to 15 are held.
  for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        word_reg[i] <= WORD_RESET;
      end else if (wr_fire && (aw_addr_reg == OFS_WORD_FIRST + 8'(4 * i))) begin
        word_reg[i] <= (word_reg[i] & ~wr_mask) | (w_data_reg & wr_mask); // [R5] [R4]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control, start and mask
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= WORD_RESET;
    end else if (wr_fire && (aw_addr_reg == OFS_CTRL) && (state_reg == ST_IDLE)) begin
      ctrl_reg <= ((ctrl_reg & ~wr_mask) | (w_data_reg & wr_mask)) & ~32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_fire && (aw_addr_reg == OFS_CTRL) && w_strb_reg[0] &&
                   w_data_reg[CTRL_START] && (state_reg == ST_IDLE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask_reg <= '0;
    end else if (wr_fire && (aw_addr_reg == OFS_INT_MASK) && w_strb_reg[0]) begin
      int_mask_reg <= w_data_reg[INT_BITS-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Command sequence
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (force_commit && (status == SC_SUCCESS)) begin
            state_reg <= ST_COMMIT; // [R11]
          end else begin
            state_reg <= ST_POST;
          end
        end
        ST_COMMIT: begin
          if (commit_cnt_reg == 8'h01) begin
            state_reg <= ST_POST; // [R11]
          end
        end
        ST_POST: begin
          state_reg <= ST_IDLE; // [R1]
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commit_cnt_reg <= 8'h00;
    end else if (state_reg == ST_DECODE) begin
      commit_cnt_reg <= COMMIT_LOAD;
    end else if ((state_reg == ST_COMMIT) && (commit_cnt_reg != 8'h00)) begin
      commit_cnt_reg <= commit_cnt_reg - 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Decoded fields and completion entry
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slba_reg <= 64'h0000_0000_0000_0000;
      blk_count_reg <= 17'h0_0000;
      attr_reg <= WORD_RESET;
    end else if (state_reg == ST_DECODE) begin
      slba_reg <= slba; // [R9]
      blk_count_reg <= blk_count; // [R13]
      attr_reg <= {limited_retry, force_commit, 2'b00, prinfo, 8'h00, incompressible,
                   sequential, latency, frequency, 6'h00, prp_mode}; // [R10] [R12] [R14]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= SC_SUCCESS;
      compl_id_reg <= 16'h0000;
    end else if (state_reg == ST_POST) begin
      status_reg <= status; // [R1] [R2] [R3]
      compl_id_reg <= ctrl_reg[31:CTRL_ID_LSB]; // [R1]
    end
  end

  assign posted_pulse = (state_reg == ST_POST);

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  // A new event in the same cycle as its write-one clear keeps the bit set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_reg <= '0;
    end else begin
      for (int b = 0; b < INT_BITS; b++) begin
        if ((b == INT_POSTED) ? posted_pulse : (posted_pulse && (status != SC_SUCCESS))) begin
          int_stat_reg[b] <= 1'b1; // [R1]
        end else if (wr_fire && (aw_addr_reg == OFS_INT_STAT) && w_strb_reg[0] &&
                     w_data_reg[b]) begin
          int_stat_reg[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Read channels
  // --------------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= OFS_INT_MASK);
    if ((s_axi_araddr >= OFS_WORD_FIRST) && (s_axi_araddr <= OFS_WORD_LAST)) begin
      rd_word = word_reg[4'((s_axi_araddr - OFS_WORD_FIRST) >> 2)];
    end else begin
      case (s_axi_araddr)
        OFS_CTRL: rd_word = {ctrl_reg[31:1], state_reg != ST_IDLE};
        OFS_SLBA_LO: rd_word = slba_reg[31:0];
        OFS_SLBA_HI: rd_word = slba_reg[63:32];
        OFS_BLK_COUNT: rd_word = {15'h0000, blk_count_reg};
        OFS_ATTR: rd_word = attr_reg;
        OFS_COMPL: rd_word = {compl_id_reg, 8'h00, status_reg};
        OFS_INT_STAT: rd_word = {30'h0000_0000, int_stat_reg};
        OFS_INT_MASK: rd_word = {30'h0000_0000, int_mask_reg};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [dv/host_model.sv]
// Host-side register bus master that issues single AXI4-Lite transfers.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and pacing
  input wire logic aclk,
  input wire logic slow,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // Status
  output logic hang
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end
  // Released address and data lines show the inverse of their last value; wstrb keeps its value.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    while (n < 64 && r === 2'h3) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) r = bresp;
      else bready <= 1'b1;
    end
    bready <= 1'b0;
    if (r === 2'h3) hang <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    while (n < 64 && r === 2'h3) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
      end else rready <= 1'b1;
    end
    rready <= 1'b0;
    if (r === 2'h3) hang <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/write_command_decoder_props.sv]
// Bus timing checks for the write command decoder.
`timescale 1ns/1ps
`default_nettype none
module write_command_decoder_props
  import write_cmd_pkg::*;
(
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_hs, rd_hs;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  AST_WRITE_ANSWER: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_READ_ANSWER: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read not answered");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_READ_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_WRITE_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  AST_BAD_READ: assert property (rd_hs &&
    (s_axi_araddr > OFS_INT_MASK || s_axi_araddr[1:0] != 2'h0) |=> s_axi_rvalid &&
    s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  AST_BAD_WRITE: assert property (wr_hs &&
    (s_axi_awaddr > OFS_INT_MASK || s_axi_awaddr[1:0] != 2'h0) |-> ##[1:2]
    (s_axi_bvalid && s_axi_bresp == AXI_SLVERR)) else $error("unmapped write accepted");
  cover property (wr_hs);
  cover property (rd_hs);
  cover property ($rose(irq));
endmodule
bind write_command_decoder write_command_decoder_props write_command_decoder_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// [dv/write_command_decoder_bench.sv]
// Self-checking bench for the write command decoder.
`timescale 1ns/1ps
`default_nettype none
module write_command_decoder_bench
  import write_cmd_pkg::*;
;
  logic aclk, aresetn, slow, hang, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ev, em, d, t, st_e, w [NUM_WORDS];
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] exp_q [$], msk_q [$];
  string nm_q [$], nm;
  int n_mismatch = 0, n_checks = 0, seed = 32'h3a594da8, n, ln, k;
  // Commands: write, pi, lr, fua, prinfo, block count field, hints.
  logic [31:0] case_tbl [6] = '{32'he50007f6, 32'h90000810, 32'h82001020,
    32'hc3000007, 32'h28ffff08, 32'h01000109};
  write_command_decoder write_command_decoder_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
  host_model host_model_i (.aclk(aclk), .slow(slow), .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready), .hang(hang));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task same(input string s, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask
  // A read notes its expected word; the monitor below compares it.
  task chk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input string s);
    exp_q.push_back(v);
    msk_q.push_back(m);
    nm_q.push_back(s);
    host_model_i.rd(a, d, r);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
      ev = exp_q.pop_front();
      em = msk_q.pop_front();
      nm = nm_q.pop_front();
      if (em != 32'h0) same(nm, ev & em, s_axi_rdata & em);
    end
    if (hang === 1'b1) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    aresetn = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk(OFS_CTRL, 32'h0, '1, "ctrl reset");
    chk(OFS_COMPL, 32'h0, '1, "compl reset");
    chk(OFS_INT_MASK, 32'h0, '1, "mask reset");
    chk(8'h50, 32'h0, '1, "unmapped read");
    same("unmapped read resp", AXI_SLVERR, r);
    host_model_i.wr(8'h52, 32'h1, r);
    same("unmapped write resp", AXI_SLVERR, r);
    for (k = 0; k < 6; k++) begin
      t = case_tbl[k];
      slow <= k[0];
      for (int i = 0; i < NUM_WORDS; i++) begin
        w[i] = $random(seed);
        if (i == W_MPTR_LO) w[i][1:0] = 2'h0;
        if (i == W_PRP1_LO) w[i][11:0] = 12'h0;
        if (i == W_DW12) w[i] = {t[29:24], w[i][9:0], t[23:8]};
        if (i == W_DW13) w[i] = {w[i][23:0], t[7:0]};
        host_model_i.wr(OFS_WORD_FIRST + 8'(4 * i), w[i], r);
      end
      host_model_i.wr(OFS_INT_MASK, (k == 0) ? 32'h0 : 32'h3, r);
      host_model_i.wr(OFS_CTRL, {16'h0a00 + 16'(k), 13'h0, t[30], t[31], 1'b1}, r);
      st_e = (t[3:0] > (t[31] ? FREQ_WRITE_MAX : FREQ_READ_MAX)) ? SC_CONFLICT :
        (!t[30] && t[26:24] != 3'h0) ? SC_BAD_PI : SC_SUCCESS;
      if (t[28] && st_e == 0) chk(OFS_CTRL, 32'h1, 32'h1, "commit busy");
      n = 0;
      d = 32'h1;
      while (d[0] !== 1'b0 && n < 50) begin
        chk(OFS_CTRL, 32'h0, 32'h0, "poll");
        n++;
      end
      if (n == 50) begin
        n_mismatch++;
        final_report();
      end
      ln = (int'(t[23:8]) + 1) * 512;
      chk(OFS_SLBA_LO, w[W_DW10], '1, "slba lo");
      chk(OFS_SLBA_HI, w[W_DW11], '1, "slba hi");
      chk(OFS_BLK_COUNT, 32'(t[23:8]) + 32'h1, '1, "count");
      chk(OFS_ATTR, {t[29:28], 2'h0, t[27:24], 8'h0, t[7:0], 6'h0,
        2'(ln > 4096) + 2'(ln > 8192)}, '1, "attr");
      chk(OFS_COMPL, {16'h0a00 + 16'(k), 8'h0, st_e[7:0]}, '1, "compl");
      chk(OFS_INT_STAT, {30'h0, st_e != 0, 1'b1}, '1, "int stat");
      same("irq set", 32'(k != 0), 32'(irq));
      host_model_i.wr(OFS_INT_STAT, 32'h3, r);
      chk(OFS_INT_STAT, 32'h0, '1, "int clear");
      same("irq clear", 32'h0, 32'(irq));
      $display("test %0d done", k);
    end
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule
`default_nettype wire
